// ===== shared/rws_pkg.sv
// Functional notes
// - Filtered overvoltage kills field on separate path.
// - Undervoltage turns the warning lamp on.
// - Low voltage: standby, every driver off.
// - Flag sense disconnection below selected threshold.
// - Regulate on supply when difference exceeded.
// - Sense loss is disconnection or difference.
// - Optional 1 V set point raise on loss.
// - Source switch filtered: 1 ms / 200 ms.
// - Option picks lamp or ignition wake source.
// - Ignition decoded as one, zero, high-Z.
// - No ignition, self-start: lamp or phase wakes.
// - No ignition, no self-start: lamp only.
// - Variant one ignition wake table.
// - Variant two with self-start wake table.
// - Monitor at field rate or half rate.
// - Monitor polarity direct or inverted.
// - Optional monitor duty clamp 5% to 95%.
// - Monitor short: cap 100 us, retry 40 ms.
// - Monitor reproduces field duty otherwise.
// - Pre-excitation shows fixed 12.5% duty.
// - First phase regulation shows 6% duty.
// - Later phase regulation excluded from duty.
// - Freeze holds until supply recovers.
// - Low voltage filtered over 150 us.
// - Overvoltage filtered over 1.25 ms.
package rws_pkg;

  localparam int CLK_HZ = 20_000_000;

  localparam real OV_FILT_MS = 1.25;
  localparam real LV_FILT_US = 150.0;
  localparam real S2B_FILT_MS = 1.0;
  localparam real B2S_FILT_MS = 200.0;
  localparam real FM_CAP_US = 100.0;
  localparam real FM_RETRY_MS = 40.0;
  localparam real PH_WINDOW_MS = 20.0;

  localparam int OV_FILT_CYC = int'($ceil(OV_FILT_MS * CLK_HZ / 1.0e3));
  localparam int LV_FILT_CYC = int'($ceil(LV_FILT_US * CLK_HZ / 1.0e6));
  localparam int S2B_FILT_CYC = int'($ceil(S2B_FILT_MS * CLK_HZ / 1.0e3));
  localparam int B2S_FILT_CYC = int'($ceil(B2S_FILT_MS * CLK_HZ / 1.0e3));
  localparam int FM_CAP_CYC = int'($floor(FM_CAP_US * CLK_HZ / 1.0e6));
  localparam int FM_RETRY_CYC = int'($ceil(FM_RETRY_MS * CLK_HZ / 1.0e3));
  localparam int PH_WINDOW_CYC = int'($ceil(PH_WINDOW_MS * CLK_HZ / 1.0e3));

  localparam int CNT_W = 23;
  localparam int PER_W = 19;

  localparam logic [6:0] PCT_MIN = 7'h05;
  localparam logic [6:0] PCT_FIRST = 7'h06;
  localparam logic [6:0] PCT_MAX = 7'h5F;

  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [7:0] CFG_RST = 8'h04;

  typedef struct packed {
    logic sys24;
    logic fm_clamp;
    logic fm_invert;
    logic fm_half;
    logic boost_en;
    logic self_start;
    logic variant_two;
    logic ign_used;
  } rws_cfg_t;

  typedef struct packed {
    logic ov_cmp;
    logic uv_cmp;
    logic lv_cmp;
    logic sense_disc_cmp;
    logic sense_diff_cmp;
    logic ign_on_cmp;
    logic ign_off_cmp;
  } rws_cmp_t;

  typedef enum logic [2:0] {
    IGN_ZERO = 3'b001,
    IGN_ONE = 3'b010,
    IGN_HIZ = 3'b100
  } rws_ign_t;

  typedef enum logic [2:0] {
    FMS_PREEX = 3'b001,
    FMS_FIRST = 3'b010,
    FMS_NORMAL = 3'b100
  } rws_fms_t;

endpackage : rws_pkg

// ===== rtl/rws_monitor.sv
`timescale 1ns/1ps
module rws_monitor import rws_pkg::*; #(
  parameter int OV_FILT = OV_FILT_CYC,
  parameter int S2B_FILT = S2B_FILT_CYC,
  parameter int B2S_FILT = B2S_FILT_CYC,
  parameter int FM_RETRY = FM_RETRY_CYC,
  parameter int PH_WINDOW = PH_WINDOW_CYC
) (
  input wire logic clk_sys, // 20 MHz system clock
  input wire logic rstn, // Asynchronous reset
  input wire logic [3:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Wait request
  input wire rws_cmp_t cmp, // Analog comparator results
  input wire logic lamp_in, // Lamp terminal level
  input wire logic phase_input, // Conditioned phase comparator
  input wire logic field_pwm, // Field drive signal
  input wire logic field_phase_reg, // Field on due to phase regulation
  input wire logic field_period_tick, // Start of field period
  input wire logic field_125hz, // Field switches at 125 Hz
  input wire logic preexcite, // Pre-excitation state
  input wire logic phase_reg_active, // Phase regulation active
  input wire logic fm_short, // Monitor over-current comparator
  output logic thr_sel_24v, // Selects 24 V thresholds
  output logic field_kill, // Independent field shutdown
  output logic field_enable, // Field driver allowed
  output logic lamp_on, // Warning lamp driver
  output logic standby, // Frozen, all drivers off
  output logic regulator_on, // Wake decision
  output logic sense_disc, // Sense disconnected
  output logic sense_loss, // Sense loss
  output logic reg_src_supply, // Regulating against supply
  output logic setpoint_boost, // Raise set point by 1 V
  output logic field_monitor_out, // Monitor level
  output logic field_monitor_oe_n, // Low while monitor driven
  output logic monitor_current_cap // Monitor current limit active
);

  logic [7:0] cfg_r;
  rws_cfg_t cfg;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [CNT_W-1:0] ov_cnt_r, lv_cnt_r, src_cnt_r, ph_cnt_r, prot_cnt_r;
  logic ov_filt_r, lv_frozen_r, src_supply_r, ph_prev_r, ph_present_r;
  logic reg_on_r, fm_retry_r, fm_lvl_r;
  rws_fms_t fms_r, fms_nxt;
  logic [PER_W-1:0] meas_len_r, meas_hi_r, per_r, hi_r, gcnt_r;

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction : sat_inc

  function automatic logic [PER_W-1:0] pct(input logic [PER_W-1:0] p, input logic [6:0] k);
    logic [PER_W+6:0] prod;
    prod = p * k;
    pct = PER_W'(prod / 7'd100);
  endfunction : pct

  // Register bus: one wait state, every access answered, unmapped reads zero.
  wire bus_req = avs_read | avs_write;
  // The write lands at the edge that sees waitrequest low, with the request still held.
  wire wr_cfg = avs_write & ack_r & (avs_address == REG_CFG);
  wire [31:0] stat_word = {20'h0, fms_r == FMS_PREEX, fms_r == FMS_FIRST, fm_retry_r,
                           ph_present_r, src_supply_r, sense_loss, sense_disc, lamp_on,
                           ov_filt_r, lv_frozen_r, reg_on_r, 1'b0};
  wire [31:0] rd_mux = (avs_address == REG_CFG) ? {24'h0, cfg_r} :
                       (avs_address == REG_STAT) ? stat_word : 32'h0;
  assign avs_waitrequest = bus_req & ~ack_r;
  assign avs_readdata = rdata_r;
  assign cfg = rws_cfg_t'(cfg_r);
  assign thr_sel_24v = cfg.sys24;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
      cfg_r <= CFG_RST;
    end else begin
      ack_r <= bus_req & ~ack_r;
      if (avs_read && !ack_r) rdata_r <= rd_mux;
      if (wr_cfg) cfg_r <= avs_writedata[7:0];
    end
  end

  // Supply supervision. Overvoltage uses its own counter and output so a fault in
  // the wake or monitor logic can never hold the field on.
  wire ov_done = ov_cnt_r >= CNT_W'(OV_FILT - 1);
  wire lv_done = lv_cnt_r >= CNT_W'(LV_FILT_CYC - 1);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ov_cnt_r <= '0;
      ov_filt_r <= 1'b0;
      lv_cnt_r <= '0;
      lv_frozen_r <= 1'b0;
    end else begin
      ov_cnt_r <= cmp.ov_cmp ? sat_inc(ov_cnt_r) : '0;
      ov_filt_r <= cmp.ov_cmp & ov_done;
      lv_cnt_r <= (cmp.lv_cmp && !lv_frozen_r) ? sat_inc(lv_cnt_r) : '0;
      if (cmp.lv_cmp && lv_done) lv_frozen_r <= 1'b1;
      else if (!cmp.lv_cmp) lv_frozen_r <= 1'b0;
    end
  end
  assign field_kill = ov_filt_r;
  assign standby = lv_frozen_r;
  assign lamp_on = cmp.uv_cmp & ~lv_frozen_r;
  assign field_enable = reg_on_r & ~lv_frozen_r & ~ov_filt_r;

  // Sense path and filtered regulation source.
  assign sense_disc = cmp.sense_disc_cmp;
  assign sense_loss = cmp.sense_disc_cmp | cmp.sense_diff_cmp;
  assign setpoint_boost = cfg.boost_en & sense_loss;
  assign reg_src_supply = src_supply_r;
  wire src_want = cmp.sense_diff_cmp;
  wire src_done = src_supply_r ? (src_cnt_r >= CNT_W'(B2S_FILT - 1))
                               : (src_cnt_r >= CNT_W'(S2B_FILT - 1));
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      src_cnt_r <= '0;
      src_supply_r <= 1'b0;
    end else if (src_want == src_supply_r) begin
      src_cnt_r <= '0;
    end else if (src_done) begin
      src_cnt_r <= '0;
      src_supply_r <= src_want;
    end else begin
      src_cnt_r <= sat_inc(src_cnt_r);
    end
  end

  // Phase presence; the detector is held cleared while frozen so it starts fresh.
  wire ph_edge = phase_input ^ ph_prev_r;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ph_prev_r <= 1'b0;
      ph_cnt_r <= '0;
      ph_present_r <= 1'b0;
    end else begin
      ph_prev_r <= phase_input;
      if (lv_frozen_r) begin
        ph_cnt_r <= '0;
        ph_present_r <= 1'b0;
      end else if (ph_edge) begin
        ph_cnt_r <= '0;
        ph_present_r <= 1'b1;
      end else if (ph_cnt_r >= CNT_W'(PH_WINDOW - 1)) begin
        ph_present_r <= 1'b0;
      end else begin
        ph_cnt_r <= sat_inc(ph_cnt_r);
      end
    end
  end

  // Wake decision. Variant two without self-start follows the variant one table.
  rws_ign_t ign_lvl;
  assign ign_lvl = cmp.ign_on_cmp ? IGN_ONE : (cmp.ign_off_cmp ? IGN_ZERO : IGN_HIZ);
  wire ss_phase = cfg.self_start & ph_present_r;
  wire wake_lamp = lamp_in | ss_phase;
  wire wake_v1 = (ign_lvl == IGN_ONE) | ((ign_lvl == IGN_HIZ) & ss_phase);
  wire wake_v2 = (ign_lvl == IGN_ONE) | ss_phase;
  wire wake_ign = (cfg.variant_two && cfg.self_start) ? wake_v2 : wake_v1;
  wire wake_nxt = ~lv_frozen_r & (cfg.ign_used ? wake_ign : wake_lamp);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) reg_on_r <= 1'b0;
    else reg_on_r <= wake_nxt;
  end
  assign regulator_on = reg_on_r;

  // Field duty measurement; phase-regulation field activity is not counted.
  wire fld_load = field_pwm & ~field_phase_reg;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meas_len_r <= '0;
      meas_hi_r <= '0;
      per_r <= '0;
      hi_r <= '0;
    end else if (field_period_tick) begin
      per_r <= meas_len_r;
      hi_r <= meas_hi_r;
      meas_len_r <= PER_W'(1);
      meas_hi_r <= PER_W'(fld_load);
    end else begin
      if (!(&meas_len_r[PER_W-2:0])) meas_len_r <= meas_len_r + 1'b1;
      if (fld_load && !(&meas_hi_r[PER_W-2:0])) meas_hi_r <= meas_hi_r + 1'b1;
    end
  end

  // Monitor state: pre-excitation, first phase regulation, then normal.
  always_comb begin
    fms_nxt = fms_r;
    unique case (fms_r)
      FMS_PREEX: if (!preexcite) fms_nxt = phase_reg_active ? FMS_FIRST : FMS_NORMAL;
      FMS_FIRST: if (preexcite) fms_nxt = FMS_PREEX;
                 else if (!phase_reg_active) fms_nxt = FMS_NORMAL;
      FMS_NORMAL: if (preexcite) fms_nxt = FMS_PREEX;
      default: fms_nxt = FMS_PREEX;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) fms_r <= FMS_PREEX;
    else fms_r <= fms_nxt;
  end

  // Monitor waveform; half rate stretches period and high time alike.
  wire half_eff = cfg.fm_half & ~field_125hz;
  wire [PER_W-1:0] mon_per = half_eff ? {per_r[PER_W-2:0], 1'b0} : per_r;
  wire [PER_W-1:0] raw_hi = half_eff ? {hi_r[PER_W-2:0], 1'b0} : hi_r;
  wire [PER_W-1:0] lo_lim = pct(mon_per, PCT_MIN);
  wire [PER_W-1:0] hi_lim = pct(mon_per, PCT_MAX);
  wire [PER_W-1:0] clamp_hi = (raw_hi < lo_lim) ? lo_lim : ((raw_hi > hi_lim) ? hi_lim : raw_hi);
  wire [PER_W-1:0] norm_hi = cfg.fm_clamp ? clamp_hi : raw_hi;
  wire [PER_W-1:0] mon_hi = (fms_r == FMS_PREEX) ? (mon_per >> 3) :
                            (fms_r == FMS_FIRST) ? pct(mon_per, PCT_FIRST) : norm_hi;
  wire gen_wrap = (gcnt_r + 1'b1) >= mon_per;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gcnt_r <= '0;
      fm_lvl_r <= 1'b0;
    end else begin
      gcnt_r <= gen_wrap ? '0 : gcnt_r + 1'b1;
      fm_lvl_r <= (gcnt_r < mon_hi) ^ cfg.fm_invert;
    end
  end

  // Short protection: cap the current, then release the pin for the retry time.
  wire fm_drive = ~lv_frozen_r & ~fm_retry_r;
  wire cap_done = prot_cnt_r >= CNT_W'(FM_CAP_CYC - 1);
  wire retry_done = prot_cnt_r >= CNT_W'(FM_RETRY - 1);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prot_cnt_r <= '0;
      fm_retry_r <= 1'b0;
    end else if (fm_retry_r) begin
      prot_cnt_r <= retry_done ? '0 : sat_inc(prot_cnt_r);
      if (retry_done) fm_retry_r <= 1'b0;
    end else if (fm_drive && fm_short) begin
      prot_cnt_r <= cap_done ? '0 : sat_inc(prot_cnt_r);
      if (cap_done) fm_retry_r <= 1'b1;
    end else begin
      prot_cnt_r <= '0;
    end
  end
  assign monitor_current_cap = fm_drive & fm_short;
  assign field_monitor_out = fm_lvl_r;
  assign field_monitor_oe_n = ~fm_drive;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_short_run;
    fm_drive && fm_short && prot_cnt_r == CNT_W'(FM_CAP_CYC - 1);
  endsequence

  a_ov_field_off: assert property (ov_filt_r |-> field_kill && !field_enable)
    else $error("field not killed on overvoltage");
  a_ov_filter_len: assert property ($rose(ov_filt_r) |-> $past(ov_cnt_r) >= CNT_W'(OV_FILT - 1))
    else $error("overvoltage acted before filter time");
  a_uv_lamp_on: assert property (cmp.uv_cmp && !standby |-> lamp_on)
    else $error("lamp off during undervoltage");
  a_lv_all_off: assert property (standby |-> !lamp_on && !field_enable && field_monitor_oe_n)
    else $error("driver active in standby");
  a_lv_filter_len: assert property ($rose(lv_frozen_r) |-> $past(lv_cnt_r) == CNT_W'(LV_FILT_CYC - 1))
    else $error("low voltage acted at wrong time");
  a_loss_boost: assert property (cmp.sense_diff_cmp && cfg.boost_en |-> setpoint_boost && sense_loss)
    else $error("set point not raised on sense loss");
  a_src_to_supply: assert property ($rose(src_supply_r) |-> $past(src_cnt_r) == CNT_W'(S2B_FILT - 1))
    else $error("supply regulation switched at wrong time");
  a_ign_one_wake: assert property (cfg.ign_used && cmp.ign_on_cmp && !standby |=> regulator_on)
    else $error("ignition one did not wake");
  a_lamp_only: assert property (!cfg.ign_used && !cfg.self_start && !lamp_in && !standby
    |=> !regulator_on)
    else $error("woke without lamp");
  a_short_retry: assert property (s_short_run |=> fm_retry_r ##1 field_monitor_oe_n)
    else $error("monitor not released after cap time");
  a_retry_length: assert property ($fell(fm_retry_r) |-> $past(prot_cnt_r) == CNT_W'(FM_RETRY - 1))
    else $error("retry delay wrong");

endmodule : rws_monitor

// ===== bench/rws_ecu_model.sv
`timescale 1ns/1ps
module rws_ecu_model (
  input wire logic clk_sys, // System clock
  input wire logic rstn, // Reset, active low
  input wire logic fm_level, // Monitor driver level
  input wire logic fm_oe_n, // Low while the driver is active
  input wire logic clr, // Clears the counts
  input wire logic meas, // Counts while high
  output int hi_cnt, // High cycles seen on the line
  output int rise_cnt // Rising edges seen on the line
);
  // The line has a pull-up, so a released driver reads high, never the last level.
  wire logic pin = fm_oe_n ? 1'h1 : fm_level;
  logic pin_d;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hi_cnt <= 0;
      rise_cnt <= 0;
      pin_d <= 1'h1;
    end else begin
      pin_d <= pin;
      if (clr) begin
        hi_cnt <= 0;
        rise_cnt <= 0;
      end else if (meas) begin
        hi_cnt <= hi_cnt + int'(pin);
        rise_cnt <= rise_cnt + int'(pin && !pin_d);
      end
    end
  end
endmodule : rws_ecu_model

// ===== bench/regulator_wake_sense_monitor_tb.sv
`timescale 1ns/1ps
module regulator_wake_sense_monitor_tb import rws_pkg::*;;
  localparam int PER = 80;
  logic clk_sys, rstn = 1'h0, avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  rws_cmp_t cmp = '0;
  logic lamp_in = 1'h0, phase_input = 1'h0, field_pwm = 1'h0, field_phase_reg = 1'h0;
  logic field_period_tick = 1'h0, field_125hz = 1'h0, preexcite = 1'h0;
  logic phase_reg_active = 1'h0, fm_short = 1'h0, ph_run = 1'h0, pr_mode = 1'h0;
  logic meas = 1'h0, clr = 1'h0;
  logic thr_sel_24v, field_kill, field_enable, lamp_on, standby, regulator_on, sense_disc;
  logic sense_loss, reg_src_supply, setpoint_boost, field_monitor_out, field_monitor_oe_n;
  logic monitor_current_cap;
  int fails = 0, checked = 0, cyc = 0, fcnt = 0, hi_c = 30, hc, rc;

  rws_monitor #(.OV_FILT(20), .S2B_FILT(16), .B2S_FILT(40), .FM_RETRY(50), .PH_WINDOW(64))
    DUT (.*);
  rws_ecu_model ecu (.clk_sys(clk_sys), .rstn(rstn), .fm_level(field_monitor_out),
    .fm_oe_n(field_monitor_oe_n), .clr(clr), .meas(meas), .hi_cnt(hc), .rise_cnt(rc));

  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Field drive stand-in: fixed period, high for the first hi_c cycles.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    fcnt <= (fcnt + 1) % PER;
    field_period_tick <= (fcnt == PER - 1);
    field_pwm <= ((fcnt + 1) % PER) < hi_c;
    field_phase_reg <= pr_mode && (((fcnt + 1) % PER) < hi_c);
    if (ph_run) phase_input <= ~phase_input;
    if (cyc == 60000) begin
      fails++;
      end_of_test();
    end
  end

  task end_of_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk

  task near(input string nm, input int s, input int e, input int tol);
    checked++;
    if (s < e - tol || s > e + tol) begin
      fails++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, s);
    end
  endtask : near

  task wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wt

  task do_rst;
    @(posedge clk_sys);
    rstn <= 1'h0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'h1;
  endtask : do_rst

  // Request held from just after an edge until the edge that sees waitrequest low.
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask : bus

  // Settles, then counts over four monitor periods; a wrong rate shows in the edge count.
  task mon(input string nm, input int mp, input int hi4, input int rises);
    wt(600);
    @(posedge clk_sys);
    clr <= 1'h1;
    @(posedge clk_sys);
    clr <= 1'h0;
    meas <= 1'h1;
    repeat (4 * mp) @(posedge clk_sys);
    meas <= 1'h0;
    wt(2);
    near(nm, hc, hi4, 6);
    near(nm, rc, rises, 1);
  endtask : mon

  function automatic logic wake_exp(input logic [2:0] c, input logic l, input logic p,
    input int g);
    if (!c[0]) return c[2] ? (l | p) : l;
    if (g == 1) return 1'h1;
    if (c[1] && c[2]) return p;
    return (g == 2) && c[2] && p;
  endfunction : wake_exp

  initial begin
    do_rst();
    bus(1'h0, REG_CFG, 32'h0);
    chk("cfg_reset", rd, 32'h00000004);
    bus(1'h1, 4'h8, 32'hFFFFFFFF);
    bus(1'h0, 4'h8, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(1'h1, REG_CFG, 32'h000000A5);
    bus(1'h0, REG_CFG, 32'h0);
    chk("cfg_rw", rd, 32'h000000A5);
    chk("thr_24v", thr_sel_24v, 1'h1);
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_sys);
      ph_run <= p[0];
      wt(100);
      bus(1'h0, REG_STAT, 32'h0);
      chk("phase_present", rd[8], p[0]);
      for (int c = 0; c < 8; c++) begin
        bus(1'h1, REG_CFG, 32'(c));
        for (int l = 0; l < 2; l++) for (int g = 0; g < 3; g++) begin
          @(posedge clk_sys);
          lamp_in <= l[0];
          cmp.ign_on_cmp <= (g == 1);
          cmp.ign_off_cmp <= (g == 0);
          wt(3);
          chk("wake", regulator_on, wake_exp(c[2:0], l[0], p[0], g));
        end
      end
    end
    @(posedge clk_sys);
    ph_run <= 1'h0;
    cmp.uv_cmp <= 1'h1;
    wt(3);
    chk("lamp_uv", lamp_on, 1'h1);
    @(posedge clk_sys);
    cmp.lv_cmp <= 1'h1;
    wt(2990);
    chk("lv_filter", standby, 1'h0);
    wt(20);
    chk("standby", standby, 1'h1);
    chk("lamp_standby", lamp_on, 1'h0);
    chk("field_standby", field_enable, 1'h0);
    bus(1'h0, REG_STAT, 32'h0);
    chk("stat_standby", rd[2], 1'h1);
    @(posedge clk_sys);
    cmp.lv_cmp <= 1'h0;
    wt(3);
    chk("unfreeze", standby, 1'h0);
    chk("lamp_back", lamp_on, 1'h1);
    @(posedge clk_sys);
    cmp.uv_cmp <= 1'h0;
    cmp.ov_cmp <= 1'h1;
    wt(18);
    chk("ov_filter", field_kill, 1'h0);
    wt(6);
    chk("ov_kill", field_kill, 1'h1);
    chk("ov_field", field_enable, 1'h0);
    @(posedge clk_sys);
    cmp.ov_cmp <= 1'h0;
    do_rst();
    wt(2);
    chk("kill_reset", field_kill, 1'h0);
    bus(1'h1, REG_CFG, 32'h00000008);
    @(posedge clk_sys);
    cmp.sense_disc_cmp <= 1'h1;
    wt(2);
    chk("disc", sense_disc, 1'h1);
    chk("loss_disc", sense_loss, 1'h1);
    chk("boost", setpoint_boost, 1'h1);
    @(posedge clk_sys);
    cmp.sense_disc_cmp <= 1'h0;
    cmp.sense_diff_cmp <= 1'h1;
    wt(10);
    chk("src_early", reg_src_supply, 1'h0);
    chk("loss_diff", sense_loss, 1'h1);
    wt(12);
    chk("src_supply", reg_src_supply, 1'h1);
    bus(1'h1, REG_CFG, 32'h0);
    wt(2);
    chk("no_boost", setpoint_boost, 1'h0);
    @(posedge clk_sys);
    cmp.sense_diff_cmp <= 1'h0;
    wt(30);
    chk("src_hold", reg_src_supply, 1'h1);
    wt(20);
    chk("src_sense", reg_src_supply, 1'h0);
    @(posedge clk_sys);
    preexcite <= 1'h1;
    mon("preex", PER, 40, 4);
    @(posedge clk_sys);
    preexcite <= 1'h0;
    phase_reg_active <= 1'h1;
    mon("first", PER, 19, 4);
    @(posedge clk_sys);
    phase_reg_active <= 1'h0;
    mon("normal", PER, 120, 4);
    bus(1'h1, REG_CFG, 32'h00000020);
    mon("invert", PER, 200, 4);
    bus(1'h1, REG_CFG, 32'h00000010);
    mon("half", 2 * PER, 240, 4);
    @(posedge clk_sys);
    field_125hz <= 1'h1;
    mon("half_125", PER, 120, 4);
    bus(1'h1, REG_CFG, 32'h00000040);
    field_125hz <= 1'h0;
    hi_c <= 2;
    mon("clamp_lo", PER, 16, 4);
    hi_c <= 79;
    mon("clamp_hi", PER, 304, 4);
    bus(1'h1, REG_CFG, 32'h0);
    hi_c <= 20;
    pr_mode <= 1'h1;
    phase_reg_active <= 1'h1;
    mon("phase_excl", PER, 0, 0);
    @(posedge clk_sys);
    pr_mode <= 1'h0;
    phase_reg_active <= 1'h0;
    hi_c <= 30;
    fm_short <= 1'h1;
    wt(3);
    chk("cap_on", monitor_current_cap, 1'h1);
    wt(1990);
    chk("cap_time", field_monitor_oe_n, 1'h0);
    wt(20);
    chk("short_off", field_monitor_oe_n, 1'h1);
    chk("cap_off", monitor_current_cap, 1'h0);
    @(posedge clk_sys);
    fm_short <= 1'h0;
    wt(25);
    chk("retry_wait", field_monitor_oe_n, 1'h1);
    wt(40);
    chk("retry_on", field_monitor_oe_n, 1'h0);
    end_of_test();
  end
endmodule : regulator_wake_sense_monitor_tb
